// ### design/svd_ctrl.sv
// supply voltage detect control and flag logic with avalon-mm slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "svd_defs.svh"

module svd_ctrl (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [13:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [2:0]  i_ch1_below_tap,
  input  wire logic [2:0]  i_ch2_below_tap,
  output logic             o_ch1_reset_req,
  output logic             o_ch2_reset_req,
  output logic             o_vdet_reset_req,
  output logic             o_low_supply_irq
);

  // ==================================================
  // state
  svd_pkg::svd_state_t s;
  svd_pkg::svd_state_t next_s;

  logic       req;
  logic       wr_go;
  logic [7:0] wd;
  logic       wr_lvl;
  logic       wr_mode;
  logic       wr_stat;
  logic       wr_mask;
  logic [1:0] clr_sticky;
  logic [1:0] clr_stat;
  logic [1:0] cur;
  logic [1:0] ev;
  logic [2:0] tap;
  logic [7:0] rd_mux;

  assign req = i_avs_read | i_avs_write;

  // ==================================================
  // register read image
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_avs_address)
      `SVD_ADDR_LVL: begin
        rd_mux[`SVD_CH2_STICKY] = s.sticky[1];
        rd_mux[`SVD_CH2_LIVE] = s.below[1]; // RULE10
        rd_mux[`SVD_CH2_THR_HI:`SVD_CH2_THR_LO] = s.thr[1];
        rd_mux[`SVD_CH1_STICKY] = s.sticky[0];
        rd_mux[`SVD_CH1_LIVE] = s.below[0]; // RULE10
        rd_mux[`SVD_CH1_THR_HI:`SVD_CH1_THR_LO] = s.thr[0];
      end
      `SVD_ADDR_MODE: begin
        // top two bits left at zero
        rd_mux[`SVD_SPARE_HI:`SVD_SPARE_LO] = s.spare; // RULE12
        rd_mux[`SVD_CH2_ACTION] = s.action[1];
        rd_mux[`SVD_CH2_ON] = s.det_on[1];
        rd_mux[`SVD_CH1_ACTION] = s.action[0];
        rd_mux[`SVD_CH1_ON] = s.det_on[0];
      end
      `SVD_ADDR_IRQ_STAT: begin
        rd_mux[1:0] = s.irq_stat;
      end
      `SVD_ADDR_IRQ_MASK: begin
        rd_mux[1:0] = s.irq_mask;
      end
      default: begin
        // unmapped words read as zero
        rd_mux = 8'h00;
      end
    endcase
  end

  // ==================================================
  // next state
  always_comb begin
    next_s = s;
    tap = 3'h0;
    cur = 2'h0;
    ev = 2'h0;

    // write lands at the edge where waitrequest is low
    wr_go = i_avs_write & s.ack & i_avs_byteenable[0];
    wd = i_avs_writedata[7:0];
    wr_lvl = wr_go & (i_avs_address == `SVD_ADDR_LVL);
    wr_mode = wr_go & (i_avs_address == `SVD_ADDR_MODE);
    wr_stat = wr_go & (i_avs_address == `SVD_ADDR_IRQ_STAT);
    wr_mask = wr_go & (i_avs_address == `SVD_ADDR_IRQ_MASK);

    // a zero written to a sticky bit clears it, a one does nothing
    clr_sticky[1] = wr_lvl & ~wd[`SVD_CH2_STICKY]; // RULE8
    clr_sticky[0] = wr_lvl & ~wd[`SVD_CH1_STICKY]; // RULE8
    clr_stat = {2{wr_stat}} & wd[1:0];

    // three stages; a tap only changes once stages two and three agree
    next_s.sync1 = {i_ch2_below_tap, i_ch1_below_tap}; // RULE17
    next_s.sync2 = s.sync1; // RULE17
    next_s.sync3 = s.sync2; // RULE17
    for (int k = 0; k < $bits(s.filt); k++) begin
      if (s.sync2[k] == s.sync3[k]) begin
        next_s.filt[k] = s.sync3[k]; // RULE17
      end
    end

    for (int ch = 0; ch < 2; ch++) begin
      tap = s.filt[ch*`SVD_TAPS +: `SVD_TAPS];
      // reserved code selects no tap and never detects
      unique case (s.thr[ch])
        `SVD_THR_TAP0: cur[ch] = tap[0]; // RULE1
        `SVD_THR_TAP1: cur[ch] = tap[1]; // RULE1
        `SVD_THR_TAP2: cur[ch] = tap[2]; // RULE1
        default:       cur[ch] = 1'b0; // RULE1
      endcase
      // a disabled channel reports nothing
      cur[ch] = cur[ch] & s.det_on[ch]; // RULE3

      // below image starts at zero when off, so enabling while low fires at once
      // both edges count; disabling while low also fires, hence mask first
      ev[ch] = (s.action[ch] == `SVD_ACTION_IRQ) & (cur[ch] != s.below[ch]); // RULE5 RULE6 RULE14 RULE2

      next_s.rst_req[ch] = (s.action[ch] == `SVD_ACTION_RESET) & cur[ch]; // RULE4 RULE15 RULE14 RULE2

      // set beats clear; nothing but a zero write takes it down
      next_s.sticky[ch] = cur[ch] | (s.sticky[ch] & ~clr_sticky[ch]); // RULE7 RULE9 RULE16
    end
    next_s.below = cur;

    // interrupt status: set wins over write-one-to-clear
    next_s.irq_stat = ev | (s.irq_stat & ~clr_stat);

    if (wr_lvl) begin
      next_s.thr[1] = wd[`SVD_CH2_THR_HI:`SVD_CH2_THR_LO];
      next_s.thr[0] = wd[`SVD_CH1_THR_HI:`SVD_CH1_THR_LO];
    end

    if (wr_mode) begin
      // stored as written; software is expected to keep them zero
      next_s.spare = wd[`SVD_SPARE_HI:`SVD_SPARE_LO]; // RULE13
      next_s.action[1] = wd[`SVD_CH2_ACTION];
      next_s.det_on[1] = wd[`SVD_CH2_ON];
      next_s.action[0] = wd[`SVD_CH1_ACTION];
      next_s.det_on[0] = wd[`SVD_CH1_ON];
    end

    if (wr_mask) begin
      next_s.irq_mask = wd[1:0];
    end

    // one wait cycle per access; read data captured on the first edge
    next_s.ack = req & ~s.ack;
    if (req & ~s.ack) begin
      next_s.rdata = rd_mux;
    end
  end

  // ==================================================
  // registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s <= '0; // RULE11
      s.thr[1] <= `SVD_CH2_THR_RST; // RULE11
      s.thr[0] <= `SVD_CH1_THR_RST; // RULE11
    end else begin
      s <= next_s;
    end
  end

  // ==================================================
  // outputs
  assign o_avs_waitrequest = req & ~s.ack;
  assign o_avs_readdata = {24'h000000, s.rdata};
  assign o_ch1_reset_req = s.rst_req[0];
  assign o_ch2_reset_req = s.rst_req[1];
  assign o_vdet_reset_req = |s.rst_req;
  assign o_low_supply_irq = |(s.irq_stat & s.irq_mask);

endmodule

// ### design/svd_defs.svh
// constants for the supply voltage detect control block
// What this block does
// [RULE1] two-bit threshold select per channel picks one of three taps; code 11 reserved
// [RULE2] per-channel action bit: 0 raises shared interrupt, 1 raises reset request
// [RULE3] per-channel enable bit turns detection on at 1, off at 0
// [RULE4] reset mode: enabled channel asserts reset request while supply below threshold
// [RULE5] interrupt mode: enabled channel raises shared interrupt when supply falls to threshold
// [RULE6] no hysteresis: interrupt raised on every comparator transition, rising too
// [RULE7] sticky detection flag per channel latches one on below-threshold detection
// [RULE8] writing zero clears sticky flag; writing one has no effect
// [RULE9] clear and new detection in same cycle leaves sticky flag set
// [RULE10] read-only live status bit shows current comparator result
// [RULE11] both registers reset only by reset; first resets to 0x20, second to zero
// [RULE12] bits 7 and 6 of mode register always read zero
// [RULE13] software always writes zero to bits 5 and 4 of mode register
// [RULE14] enabling while already below threshold raises selected request at once
// [RULE15] reset request stays asserted as long as supply stays below threshold
// [RULE16] sticky flag survives recovery and disable; only software zero write clears it
// [RULE17] comparator outputs are synchronised before driving flags, interrupt or reset
`ifndef SVD_DEFS_SVH
`define SVD_DEFS_SVH

// ==================================================
// register indices and byte addresses
`define SVD_IDX_LVL      12'hFC6
`define SVD_IDX_MODE     12'hFC7
`define SVD_IDX_IRQ_STAT 12'hFC8
`define SVD_IDX_IRQ_MASK 12'hFC9
`define SVD_ADDR_LVL      {`SVD_IDX_LVL, 2'h0}
`define SVD_ADDR_MODE     {`SVD_IDX_MODE, 2'h0}
`define SVD_ADDR_IRQ_STAT {`SVD_IDX_IRQ_STAT, 2'h0}
`define SVD_ADDR_IRQ_MASK {`SVD_IDX_IRQ_MASK, 2'h0}

// ==================================================
// level and flags register fields
`define SVD_CH2_STICKY 7
`define SVD_CH2_LIVE   6
`define SVD_CH2_THR_HI 5
`define SVD_CH2_THR_LO 4
`define SVD_CH1_STICKY 3
`define SVD_CH1_LIVE   2
`define SVD_CH1_THR_HI 1
`define SVD_CH1_THR_LO 0

// ==================================================
// mode and enable register fields
`define SVD_SPARE_HI   5
`define SVD_SPARE_LO   4
`define SVD_CH2_ACTION 3
`define SVD_CH2_ON     2
`define SVD_CH1_ACTION 1
`define SVD_CH1_ON     0

// ==================================================
// codes and reset values
`define SVD_THR_TAP0     2'h0
`define SVD_THR_TAP1     2'h1
`define SVD_THR_TAP2     2'h2
`define SVD_CH2_THR_RST  2'h2
`define SVD_CH1_THR_RST  2'h0
`define SVD_ACTION_IRQ   1'h0
`define SVD_ACTION_RESET 1'h1
`define SVD_TAPS         3

`endif

// ### design/svd_pkg.sv
// types of the supply voltage detect control block
package svd_pkg;

  // ==================================================
  // whole state of the controller
  typedef struct packed {
    logic [5:0]      sync1;
    logic [5:0]      sync2;
    logic [5:0]      sync3;
    logic [5:0]      filt;
    logic [1:0]      below;
    logic [1:0]      sticky;
    logic [1:0][1:0] thr;
    logic [1:0]      action;
    logic [1:0]      det_on;
    logic [1:0]      spare;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_mask;
    logic [1:0]      rst_req;
    logic            ack;
    logic [7:0]      rdata;
  } svd_state_t;

endpackage

// ### tb/svd_chk_assertions.sv
// port assertions for the supply voltage detect control block
`timescale 1ns/1ps
module svd_chk (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [13:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [2:0]  i_ch1_below_tap,
  input wire logic [2:0]  i_ch2_below_tap,
  input wire logic        o_ch1_reset_req,
  input wire logic        o_ch2_reset_req,
  input wire logic        o_vdet_reset_req,
  input wire logic        o_low_supply_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========
  // sequences and properties
  sequence s_req; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
  // window free of writes, so no enable change can explain a drop
  sequence s_low1; (i_ch1_below_tap == 3'h7 && !i_avs_write) [*6]; endsequence
  property p_or; o_vdet_reset_req == (o_ch1_reset_req || o_ch2_reset_req); endproperty
  property p_wait; s_req |=> !o_avs_waitrequest; endproperty
  property p_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest; endproperty
  property p_b76; i_avs_read && !o_avs_waitrequest && i_avs_address == 14'h3F1C |-> o_avs_readdata[7:6] == 2'h0;
  endproperty
  property p_rst; $past(i_rst) |-> !o_vdet_reset_req && !o_low_supply_irq; endproperty
  property p_r1; $rose(o_ch1_reset_req) |-> $past(|i_ch1_below_tap, 4); endproperty
  property p_r2; $rose(o_ch2_reset_req) |-> $past(|i_ch2_below_tap, 4); endproperty
  property p_hold; s_low1 ##0 $past(o_ch1_reset_req) |-> o_ch1_reset_req; endproperty
  property p_irq; $fell(o_low_supply_irq) |-> $past(i_avs_write); endproperty
  a_or: assert property (p_or) else $error("combined reset wrong");
  a_wait: assert property (p_wait) else $error("no bus answer");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_b76: assert property (p_b76) else $error("mode top bits set");
  a_rst: assert property (p_rst) else $error("request after reset");
  a_r1: assert property (p_r1) else $error("ch1 reset too early");
  a_r2: assert property (p_r2) else $error("ch2 reset too early");
  a_hold: assert property (p_hold) else $error("reset request dropped");
  a_irq: assert property (p_irq) else $error("irq fell by itself");
endmodule
bind svd_ctrl svd_chk u_chk (.*);

// ### tb/svd_cmp_model.sv
// comparator model: supply in millivolts to per-tap below flags
`timescale 1ns/1ps
module svd_cmp_model #(
  parameter int CH1_T1 = 4200,
  parameter int CH1_T2 = 3900
) (
  input  wire logic [12:0] i_supply_mv,
  output logic      [2:0]  o_ch1_below_tap,
  output logic      [2:0]  o_ch2_below_tap
);
  // no hysteresis, as the real comparators
  assign o_ch1_below_tap = {i_supply_mv < CH1_T2, i_supply_mv < CH1_T1, i_supply_mv < 4500};
  assign o_ch2_below_tap = {i_supply_mv < 2850, i_supply_mv < 3150, i_supply_mv < 3700};
endmodule

// ### tb/svd_ctrl_test.sv
// self-checking bench for the supply voltage detect control block
`timescale 1ns/1ps
`include "svd_defs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module svd_ctrl_test;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [13:0] adr = 14'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [12:0] mv = 13'h1388;
  logic [31:0] got;
  logic [2:0]  tab [4] = '{3'h1, 3'h3, 3'h4, 3'h6};
  wire  [31:0] rdata;
  wire  [2:0]  t1, t2;
  wire         busy, q1, q2, qv, irq;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  svd_cmp_model cmp (.i_supply_mv(mv), .o_ch1_below_tap(t1), .o_ch2_below_tap(t2));
  svd_ctrl uut (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(busy),
    .i_ch1_below_tap(t1), .i_ch2_below_tap(t2), .o_ch1_reset_req(q1), .o_ch2_reset_req(q2),
    .o_vdet_reset_req(qv), .o_low_supply_irq(irq));
  // ==========
  // tasks
  task automatic complete_run;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge i_clock);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    // waitrequest taken at the rising edge, before the slave's own update lands
    do @(posedge i_clock); while (busy !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [13:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(n, {24'h000000, e}, got)
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  initial forever #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    rdc("lvl", `SVD_ADDR_LVL, 8'h20);
    rdc("mode", `SVD_ADDR_MODE, 8'h00);
    rdc("unmapped", 14'h0000, 8'h00);
    mv <= 13'h0BB8;
    bus(1'b1, `SVD_ADDR_MODE, 8'h04);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `SVD_ADDR_LVL, {2'h0, tab[k][2:1], 4'h0});
      wt(6);
      // clear again under the new threshold; a detection in that cycle keeps the flag
      bus(1'b1, `SVD_ADDR_LVL, {2'h0, tab[k][2:1], 4'h0});
      rdc("ch2 lvl", `SVD_ADDR_LVL, {{2{tab[k][0]}}, tab[k][2:1], 4'h0});
    end
    mv <= 13'h1388;
    wt(6);
    bus(1'b1, `SVD_ADDR_LVL, 8'h00);
    bus(1'b1, `SVD_ADDR_IRQ_STAT, 8'h03);
    bus(1'b1, `SVD_ADDR_IRQ_MASK, 8'h02);
    rdc("mask", `SVD_ADDR_IRQ_MASK, 8'h02);
    wt(1);
    `CHK("irq idle", 1'b0, irq)
    @(posedge i_clock);
    mv <= 13'h0BB8;
    wt(6);
    `CHK("irq fall", 1'b1, irq)
    rdc("stat", `SVD_ADDR_IRQ_STAT, 8'h02);
    bus(1'b1, `SVD_ADDR_IRQ_STAT, 8'h02);
    wt(1);
    `CHK("irq clr", 1'b0, irq)
    @(posedge i_clock);
    mv <= 13'h1388;
    wt(6);
    `CHK("irq rise", 1'b1, irq)
    bus(1'b1, `SVD_ADDR_IRQ_MASK, 8'h00);
    wt(1);
    `CHK("irq mask", 1'b0, irq)
    rdc("recovered", `SVD_ADDR_LVL, 8'h80);
    bus(1'b1, `SVD_ADDR_MODE, 8'h00);
    rdc("disabled", `SVD_ADDR_LVL, 8'h80);
    bus(1'b1, `SVD_ADDR_LVL, 8'h80);
    rdc("w1 keep", `SVD_ADDR_LVL, 8'h80);
    bus(1'b1, `SVD_ADDR_LVL, 8'h00);
    rdc("w0 clear", `SVD_ADDR_LVL, 8'h00);
    bus(1'b1, `SVD_ADDR_LVL, 8'h88);
    rdc("no set", `SVD_ADDR_LVL, 8'h00);
    be <= 4'h0;
    bus(1'b1, `SVD_ADDR_LVL, 8'h01);
    be <= 4'hF;
    rdc("lane off", `SVD_ADDR_LVL, 8'h00);
    mv <= 13'h0DAC;
    bus(1'b1, `SVD_ADDR_MODE, 8'hCF);
    wt(6);
    `CHK("ch1 req", 1'b1, q1)
    `CHK("ch2 req", 1'b1, q2)
    `CHK("any req", 1'b1, qv)
    rdc("mode rd", `SVD_ADDR_MODE, 8'h0F);
    rdc("both lvl", `SVD_ADDR_LVL, 8'hCC);
    wt(10);
    `CHK("req held", 1'b1, q1)
    @(posedge i_clock);
    mv <= 13'h1388;
    wt(6);
    `CHK("req off", 1'b0, qv)
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    rdc("mode rst2", `SVD_ADDR_MODE, 8'h00);
    rdc("lvl rst2", `SVD_ADDR_LVL, 8'h20);
    complete_run();
  end
endmodule
